// *** hw/sbc_pkg.sv ***
// constants for the management-bus byte configuration slave
// assumes a 20 MHz system clock sampling the bus pins
package sbc_pkg;
	localparam logic [6:0] SBC_SLAVE_ADDR = 7'h69;
	localparam logic [6:0] SBC_IDX_FREQ = 7'h00;
	localparam logic [6:0] SBC_IDX_EN1 = 7'h01;
	localparam logic [6:0] SBC_IDX_EN2 = 7'h02;
	localparam logic [7:0] SBC_RST_FREQ = 8'h00;
	localparam logic [7:0] SBC_RST_EN1 = 8'hFF;
	localparam logic [7:0] SBC_RST_EN2 = 8'h7F;
	localparam logic [7:0] SBC_EN2_MASK = 8'h7F;
	localparam int SBC_CMD_BYTE_BIT = 7;
	localparam int SBC_FREQ_LSB = 0;
	localparam int SBC_FREQ_MSB = 4;
	localparam int SBC_SPREAD_LSB = 5;
	localparam int SBC_SPREAD_MSB = 7;
	localparam logic [3:0] SBC_BITS_LAST = 4'h7;
	localparam logic [3:0] SBC_BITS_ACK = 4'h8;
	localparam logic [3:0] SBC_BITS_PRE = 4'hF;
	typedef enum logic [2:0] {
		SBC_IDLE = 3'b000,
		SBC_ADDR = 3'b001,
		SBC_CMD = 3'b011,
		SBC_DATA = 3'b010,
		SBC_READ = 3'b110,
		SBC_DONE = 3'b111
	} sbc_state_e;
endpackage

// *** hw/sbc_slave.sv ***
// byte-indexed configuration slave on a two-wire management bus
// assumes bus pins are asynchronous to mclk and sampled by it
`timescale 1ns/1ns
`default_nettype none
module sbc_slave
	import sbc_pkg::*;
(
	input wire logic mclk, // system clock
	input wire logic sys_rst, // synchronous reset, high
	input wire logic scl_in, // bus clock pin level
	input wire logic sda_in, // bus data pin level
	output logic sda_out, // data drive value, always low
	output logic sda_oe, // high pulls data low
	output logic [4:0] soft_freq_code, // frequency select code
	output logic [2:0] spread_code, // spread select code
	output logic [7:0] clock_enables_first, // enable byte one
	output logic [6:0] clock_enables_second // enable byte two
);
	logic [1:0] scl_sync, sda_sync;
	logic scl_d, sda_d;
	sbc_state_e state, next_state;
	logic [3:0] bit_cnt, next_bit_cnt;
	logic [7:0] shreg, next_shreg;
	logic [6:0] index, next_index;
	logic oe, next_oe;
	logic is_read, next_is_read;
	logic [7:0] reg0, next_reg0, reg1, next_reg1, reg2, next_reg2;
	logic [7:0] rd_byte;
	logic scl_rise, scl_fall, start_c, stop_c;

	assign scl_rise = scl_sync[1] & ~scl_d;
	assign scl_fall = ~scl_sync[1] & scl_d;
	assign start_c = scl_sync[1] & scl_d & sda_d & ~sda_sync[1];
	assign stop_c = scl_sync[1] & scl_d & ~sda_d & sda_sync[1];
	assign sda_out = 1'b0;
	assign sda_oe = oe;
	assign soft_freq_code = reg0[SBC_FREQ_MSB:SBC_FREQ_LSB];
	assign spread_code = reg0[SBC_SPREAD_MSB:SBC_SPREAD_LSB];
	assign clock_enables_first = reg1;
	assign clock_enables_second = reg2[6:0];

	always_comb begin
		case (index)
			SBC_IDX_FREQ: rd_byte = reg0;
			SBC_IDX_EN1: rd_byte = reg1;
			SBC_IDX_EN2: rd_byte = reg2 & SBC_EN2_MASK;
			default: rd_byte = 8'h00;
		endcase
	end

	always_comb begin
		next_state = state;
		next_bit_cnt = bit_cnt;
		next_shreg = shreg;
		next_index = index;
		next_oe = oe;
		next_is_read = is_read;
		next_reg0 = reg0;
		next_reg1 = reg1;
		next_reg2 = reg2;
		if (start_c) begin
			next_state = SBC_ADDR;
			next_bit_cnt = SBC_BITS_PRE;
			next_oe = 1'b0;
		end else if (stop_c) begin
			next_state = SBC_IDLE;
			next_oe = 1'b0;
		end else if (scl_rise && state != SBC_IDLE && state != SBC_DONE) begin
			if (bit_cnt <= SBC_BITS_LAST) begin
				next_shreg = {shreg[6:0], sda_sync[1]};
			end else if (state == SBC_READ && sda_sync[1]) begin
				next_state = SBC_DONE; // host not-acknowledge
			end
		end else if (scl_fall) begin
			case (state)
				SBC_IDLE, SBC_DONE: next_oe = 1'b0;
				default: begin
					if (bit_cnt == SBC_BITS_PRE) begin
						// the fall that follows a start only opens bit one
						next_bit_cnt = 4'h0;
					end else if (bit_cnt == SBC_BITS_LAST) begin
						next_bit_cnt = SBC_BITS_ACK;
						next_oe = 1'b1;
						case (state)
							SBC_ADDR: begin
								next_is_read = shreg[0];
								if (shreg[7:1] != SBC_SLAVE_ADDR) begin
									next_oe = 1'b0;
									next_state = SBC_IDLE;
								end else if (shreg[0] && !is_read) begin
									next_oe = 1'b0;
									next_state = SBC_IDLE;
								end
							end
							SBC_CMD: begin
								if (!shreg[SBC_CMD_BYTE_BIT]) begin
									next_oe = 1'b0;
									next_state = SBC_IDLE;
								end else begin
									next_index = shreg[6:0];
								end
							end
							SBC_DATA: begin
								case (index)
									SBC_IDX_FREQ: next_reg0 = shreg;
									SBC_IDX_EN1: next_reg1 = shreg;
									SBC_IDX_EN2: next_reg2 = shreg & SBC_EN2_MASK;
									default: next_reg0 = reg0;
								endcase
							end
							SBC_READ: next_oe = 1'b0;
							default: next_oe = 1'b0;
						endcase
					end else if (bit_cnt == SBC_BITS_ACK) begin
						next_bit_cnt = 4'h0;
						next_oe = 1'b0;
						case (state)
							SBC_ADDR: begin
								if (is_read) begin
									next_state = SBC_READ;
									next_shreg = rd_byte;
									next_oe = ~rd_byte[7];
								end else begin
									next_state = SBC_CMD;
								end
							end
							SBC_CMD: begin
								next_state = SBC_DATA;
								next_is_read = 1'b1; // allows read redirect
							end
							SBC_DATA: next_state = SBC_DONE;
							SBC_READ: next_state = SBC_READ;
							default: next_state = SBC_IDLE;
						endcase
					end else begin
						next_bit_cnt = bit_cnt + 4'h1;
						if (state == SBC_READ) begin
							next_oe = ~shreg[7];
						end
					end
				end
			endcase
		end
		if (next_state == SBC_IDLE) begin
			next_is_read = 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		scl_sync <= {scl_sync[0], scl_in};
		sda_sync <= {sda_sync[0], sda_in};
		if (sys_rst) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
			state <= SBC_IDLE;
			bit_cnt <= 4'h0;
			shreg <= 8'h00;
			index <= 7'h00;
			oe <= 1'b0;
			is_read <= 1'b0;
			reg0 <= SBC_RST_FREQ;
			reg1 <= SBC_RST_EN1;
			reg2 <= SBC_RST_EN2;
		end else begin
			scl_d <= scl_sync[1];
			sda_d <= sda_sync[1];
			state <= next_state;
			bit_cnt <= next_bit_cnt;
			shreg <= next_shreg;
			index <= next_index;
			oe <= next_oe;
			is_read <= next_is_read;
			reg0 <= next_reg0;
			reg1 <= next_reg1;
			reg2 <= next_reg2;
		end
	end

	a_reserved_zero: assert property (
		@(posedge mclk) disable iff (sys_rst) !reg2[7])
		else $error("reserved enable bit set");
	a_bad_cmd_idle: assert property (
		@(posedge mclk) disable iff (sys_rst)
		(state == SBC_CMD && scl_fall && bit_cnt == SBC_BITS_LAST
		&& !shreg[7] && !start_c && !stop_c) |=> state == SBC_IDLE)
		else $error("block command not rejected");
	a_addr_nomatch: assert property (
		@(posedge mclk) disable iff (sys_rst)
		(state == SBC_ADDR && scl_fall && bit_cnt == SBC_BITS_LAST
		&& shreg[7:1] != SBC_SLAVE_ADDR && !start_c && !stop_c) |=> !oe)
		else $error("foreign address acknowledged");
	a_addr_ack: assert property (
		@(posedge mclk) disable iff (sys_rst)
		(state == SBC_ADDR && scl_fall && bit_cnt == SBC_BITS_LAST
		&& shreg == {SBC_SLAVE_ADDR, 1'b0} && !start_c && !stop_c) |=> oe)
		else $error("own address not acknowledged");
	a_write_store: assert property (
		@(posedge mclk) disable iff (sys_rst)
		(state == SBC_DATA && scl_fall && bit_cnt == SBC_BITS_LAST
		&& index == SBC_IDX_EN1 && !start_c && !stop_c)
		|=> reg1 == $past(shreg) && reg0 == $past(reg0))
		else $error("write byte not stored");
	a_freq_map: assert property (
		@(posedge mclk) disable iff (sys_rst)
		(state == SBC_DATA && scl_fall && bit_cnt == SBC_BITS_LAST
		&& index == SBC_IDX_FREQ && !start_c && !stop_c)
		|=> soft_freq_code == $past(shreg[SBC_FREQ_MSB:SBC_FREQ_LSB]))
		else $error("freq code not written");
	a_read_load: assert property (
		@(posedge mclk) disable iff (sys_rst)
		(state == SBC_ADDR && scl_fall && bit_cnt == SBC_BITS_ACK && is_read
		&& index == SBC_IDX_EN1 && !start_c && !stop_c)
		|=> state == SBC_READ && shreg == reg1)
		else $error("read byte not loaded");
endmodule
`default_nettype wire

// *** verif/sbc_host.sv ***
// bus host model: drives the bus clock and open-drain data
// assumes the bench resolves data with a pull-up
`timescale 1ns/1ns
`default_nettype none
module sbc_host (
	input wire logic mclk, // system clock
	input wire logic sda, // resolved data line
	output logic scl, // bus clock
	output logic sda_drv // host data, 1 releases
);
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	task automatic ph(input logic c, input logic d, input int n);
		scl <= c;
		sda_drv <= d;
		repeat (n) @(posedge mclk);
	endtask
	// also serves as repeated start after an acknowledge bit
	task automatic start();
		ph(1'b0, sda_drv, 2);
		ph(1'b0, 1'b1, 2);
		ph(1'b1, 1'b1, 4);
		ph(1'b1, 1'b0, 4);
		ph(1'b0, 1'b0, 2);
	endtask
	task automatic stop();
		ph(1'b0, sda_drv, 2);
		ph(1'b0, 1'b0, 2);
		ph(1'b1, 1'b0, 4);
		ph(1'b1, 1'b1, 4);
	endtask
	// 400 ns bit; data moves only mid-way through the low phase
	task automatic bitx(input logic d, output logic r);
		ph(1'b0, sda_drv, 2);
		ph(1'b0, d, 2);
		ph(1'b1, d, 4);
		r = sda;
	endtask
	task automatic wbyte(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bitx(b[i], r);
		bitx(1'b1, r);
		ack = ~r;
	endtask
	task automatic rbyte(output logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--) bitx(1'b1, b[i]);
		bitx(1'b1, r);
	endtask
endmodule
`default_nettype wire

// *** verif/smbus_byte_config_slave_bench.sv ***
// bench: random indexed writes and reads through the host model
// assumes the slave answers at its fixed address
`timescale 1ns/1ns
`default_nettype none
module smbus_byte_config_slave_bench;
	import sbc_pkg::*;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic scl, sda_drv, sda_out, sda_oe;
	logic [4:0] soft_freq_code;
	logic [2:0] spread_code;
	logic [7:0] clock_enables_first, d, q;
	logic [6:0] clock_enables_second, i;
	logic [2:0] a;
	logic [7:0] regs [3];
	int n_errors = 0;
	int comparisons = 0;
	wire logic sda = sda_drv & (sda_oe ? sda_out : 1'b1);
	localparam logic [7:0] WA = {SBC_SLAVE_ADDR, 1'b0};
	always #25 mclk = ~mclk;
	sbc_host host (.mclk(mclk), .sda(sda), .scl(scl), .sda_drv(sda_drv));
	sbc_slave dut (.mclk(mclk), .sys_rst(sys_rst), .scl_in(scl),
		.sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
		.soft_freq_code(soft_freq_code), .spread_code(spread_code),
		.clock_enables_first(clock_enables_first),
		.clock_enables_second(clock_enables_second));
	function automatic logic [7:0] exp_rd(input logic [6:0] x);
		return (x < 7'h03) ? regs[x] : 8'h00;
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic chk_out();
		chk({spread_code, soft_freq_code}, regs[0]);
		chk(clock_enables_first, regs[1]);
		chk({1'b0, clock_enables_second}, regs[2]);
	endtask
	task automatic wr(input logic [7:0] ad, input logic [7:0] c,
			input logic [7:0] v);
		a = 3'b000;
		host.start();
		host.wbyte(ad, a[2]);
		if (a[2]) host.wbyte(c, a[1]);
		if (a[1]) host.wbyte(v, a[0]);
		host.stop();
	endtask
	task automatic rd(input logic [7:0] c);
		host.start();
		host.wbyte(WA, a[2]);
		host.wbyte(c, a[1]);
		host.start();
		host.wbyte(WA | 8'h01, a[0]);
		host.rbyte(q);
		host.stop();
	endtask
	task automatic report_and_stop();
		if (n_errors == 0 && comparisons > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge mclk);
		n_errors++;
		report_and_stop();
	end
	initial begin
		regs = '{SBC_RST_FREQ, SBC_RST_EN1, SBC_RST_EN2};
		void'($urandom(87));
		repeat (8) @(posedge mclk);
		sys_rst <= 1'b0;
		repeat (4) @(posedge mclk);
		chk_out();
		for (int k = 0; k < 10; k++) begin
			i = (k < 4) ? 7'(k) : 7'($urandom % 4);
			d = (k == 2) ? 8'hFF : 8'($urandom);
			wr(WA, {1'b1, i}, d);
			chk({5'h00, a}, 8'h07);
			if (i < 7'h03) regs[i] = (i == 7'h02) ? d & SBC_EN2_MASK : d;
			chk_out();
			rd({1'b1, i});
			chk({5'h00, a}, 8'h07);
			chk(q, exp_rd(i));
		end
		sys_rst <= 1'b1;
		repeat (8) @(posedge mclk);
		sys_rst <= 1'b0;
		repeat (4) @(posedge mclk);
		regs = '{SBC_RST_FREQ, SBC_RST_EN1, SBC_RST_EN2};
		chk_out();
		wr(WA ^ 8'h02, 8'h80, 8'h5A);
		chk({5'h00, a}, 8'h00);
		wr(WA, 8'h01, 8'h5A);
		chk({5'h00, a}, 8'h04);
		chk_out();
		report_and_stop();
	end
endmodule
`default_nettype wire
